// File: term_cmd_defines.vh
// Constants for the terminal-side capability and secure channel command controller.
// How it works
// R1: Capability command P1=P2=00, Lc, no Le.
// R2: Data starts tag A9, length, nested objects.
// R3: Card accepts trailing private tags b8b7=11.
// R4: Send power supply object before first select.
// R5: Power object 80, length 03, three bytes.
// R6: Clock byte in 0.1 MHz, FF none.
// R7: Report only 10, 30 or 60 mA.
// R8: Extended channels announced by tag 81 length 00.
// R9: Card treats extended object as zero length.
// R10: Interface object 82 len 01, b1 frontend.
// R11: Card ignores extra interface object bytes.
// R12: Tag 83 reserved, card need not interpret.
// R13: Payload wrapped 73 if TLV, else 53.
// R14: Command data split in blocks of 255.
// R15: P2 b8..b6 block op, b5..b1 zero.
// R16: Card answers 63F1 while segments outstanding.
// R17: Card answers 62F3 after last with response.
// R18: Response fetched first/next, 62F1 while more.
// R19: Last response segment ends with 9000.
// R20: P1 b3..b1 sub-procedure, b8..b5 zero.
// R21: Card ignores reserved parameter bits.
// R22: Capability sent only if card advertises it.
// R23: Card opens at most three extra channels; the card model allows 19 once tag 81 follows power.
// R24: First block restarts command reassembly.
`ifndef TERM_CMD_DEFINES_VH
`define TERM_CMD_DEFINES_VH
`define INS_TERM_CAP 8'hAA
`define INS_SEC_CHAN 8'h73
`define TAG_CAP_TEMPLATE 8'hA9
`define TAG_POWER 8'h80
`define LEN_POWER 8'h03
`define TAG_EXT_CHAN 8'h81
`define LEN_EXT_CHAN 8'h00
`define TAG_IFACE 8'h82
`define LEN_IFACE 8'h01
`define TAG_WRAP_TLV 8'h73
`define TAG_WRAP_RAW 8'h53
`define MAX_BLOCK 8'hFF
`define P2_FIRST_CMD 8'h80
`define P2_NEXT_CMD 8'h00
`define P2_FIRST_RSP 8'hA0
`define P2_NEXT_RSP 8'h20
`define MA_10 8'h0A
`define MA_30 8'h1E
`define MA_60 8'h3C
`define CLK_NONE 8'hFF
`define CLK_MIN 8'h0A
`define SW_MORE_CMD 16'h63F1
`define SW_RSP_READY 16'h62F3
`define SW_MORE_RSP 16'h62F1
`define SW_OK 16'h9000
`define REG_CTRL 4'h0
`define REG_CAP 4'h1
`define REG_SC 4'h2
`define REG_STATUS 4'h3
`define REG_SW 4'h4
`define REG_RXDATA 4'h5
`define REG_TXDATA 4'h6
`define CTRL_START_CAP 0
`define CTRL_START_SC 1
`define CTRL_SESSION 2
`define CTRL_SELECT 3
`define ST_BUSY 0
`define ST_DONE 1
`define ST_ERROR 2
`define ST_CAP_SENT 3
`define ST_SEL_OK 4
`endif

// File: apdu_header.v
// Builds the command header for the two supported commands.
`timescale 1ns/10ps
`include "term_cmd_defines.vh"
module apdu_header
(
	input wire is_sc,
	input wire [2:0] sub_proc,
	input wire [7:0] p2_code,
	output wire [7:0] ins,
	output wire [7:0] p1,
	output wire [7:0] p2
);
	// Header fields; P1 and P2 are zero for the capability command.
	assign ins = is_sc ? `INS_SEC_CHAN : `INS_TERM_CAP;
	// R20: sub-procedure field
	assign p1 = is_sc ? {5'h00, sub_proc} : 8'h00;
	// R15: block operation field
	assign p2 = is_sc ? {p2_code[7:5], 5'h00} : 8'h00;
endmodule

// File: cap_byte_gen.v
// Produces the bytes of the terminal capability data field by index.
`timescale 1ns/10ps
`include "term_cmd_defines.vh"
module cap_byte_gen
(
	input wire [7:0] idx,
	input wire [7:0] volt_class,
	input wire [1:0] ma_sel,
	input wire [7:0] clk_code,
	input wire ext_chan,
	input wire iface_on,
	input wire frontend,
	output reg [7:0] data_byte,
	output wire [7:0] total_len
);
	wire [7:0] inner_len;
	reg [7:0] ma;
	reg [7:0] k;
	// R7: only three current steps can be reported.
	always @*
	begin
		case (ma_sel)
			2'h1: ma = `MA_30;
			2'h2: ma = `MA_60;
			default: ma = `MA_10;
		endcase
	end
	// R2: template length covers nested objects.
	assign inner_len = 8'h05 + (ext_chan ? 8'h02 : 8'h00) + (iface_on ? 8'h03 : 8'h00);
	assign total_len = inner_len + 8'h02;
	// R5: objects in fixed order, power first.
	always @*
	begin
		k = idx - 8'h07;
		if (!ext_chan && idx >= 8'h07)
			k = idx - 8'h05;
		data_byte = 8'h00;
		case (idx)
			8'h00: data_byte = `TAG_CAP_TEMPLATE;
			8'h01: data_byte = inner_len;
			8'h02: data_byte = `TAG_POWER;
			8'h03: data_byte = `LEN_POWER;
			8'h04: data_byte = volt_class;
			8'h05: data_byte = ma;
			// R6: clock code, FF means not reported.
			8'h06: data_byte = (clk_code < `CLK_MIN) ? `CLK_NONE : clk_code;
			default:
			begin
				// R8: extended channel object has zero length.
				if (ext_chan && idx == 8'h07)
					data_byte = `TAG_EXT_CHAN;
				else if (ext_chan && idx == 8'h08)
					data_byte = `LEN_EXT_CHAN;
				// R10: interface object, b1 only.
				else if (iface_on && k == 8'h02)
					data_byte = `TAG_IFACE;
				else if (iface_on && k == 8'h03)
					data_byte = `LEN_IFACE;
				else if (iface_on && k == 8'h04)
					data_byte = {7'h00, frontend};
			end
		endcase
	end
endmodule

// File: term_cmd_ctrl.v
// Terminal-side controller issuing capability and chained secure channel commands.
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "term_cmd_defines.vh"
module term_cmd_ctrl
(
	input wire aclk,
	input wire aresetn,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg cmd_start,
	output reg [7:0] cmd_ins,
	output reg [7:0] cmd_p1,
	output reg [7:0] cmd_p2,
	output reg [7:0] cmd_lc,
	output reg [7:0] cmd_le,
	output reg cmd_data_valid,
	output reg [7:0] cmd_data,
	input wire cmd_data_ready,
	input wire rsp_valid,
	input wire [7:0] rsp_data,
	input wire rsp_done,
	input wire [15:0] rsp_sw,
	input wire card_cap_supported
);
	localparam S_IDLE = 3'h0;
	localparam S_HDR = 3'h1;
	localparam S_DATA = 3'h2;
	localparam S_WAIT = 3'h3;
	localparam S_NEXT = 3'h4;
	reg [2:0] state;
	reg [2:0] next_state;
	reg cap_sync1;
	reg cap_sync;
	reg is_sc;
	reg [7:0] cap_cfg_volt;
	reg [1:0] cap_cfg_ma;
	reg [7:0] cap_cfg_clk;
	reg cap_cfg_ext;
	reg cap_cfg_iface;
	reg cap_cfg_front;
	reg [2:0] sc_sub;
	reg sc_tlv;
	reg [15:0] sc_total;
	reg [15:0] sent;
	reg [7:0] blk_cnt;
	reg [7:0] idx;
	reg rsp_phase;
	reg first_blk;
	reg [7:0] p2_code;
	reg busy;
	reg done;
	reg err;
	reg cap_sent;
	reg sel_ok;
	reg [15:0] last_sw;
	reg [7:0] rx_byte;
	reg [7:0] tx_byte;
	reg tx_full;
	reg aw_held;
	reg w_held;
	reg [3:0] aw_idx;
	reg [31:0] w_hold;
	wire [7:0] hdr_ins;
	wire [7:0] hdr_p1;
	wire [7:0] hdr_p2;
	wire [7:0] cap_byte;
	wire [7:0] cap_len;
	wire [15:0] remain;
	wire [7:0] blk_len;
	wire wr_fire;
	wire [3:0] ar_idx;
	wire sc_byte_ok;
	wire more_blk;

	apdu_header u_hdr
	(
		.is_sc(is_sc),
		.sub_proc(sc_sub),
		.p2_code(p2_code),
		.ins(hdr_ins),
		.p1(hdr_p1),
		.p2(hdr_p2)
	);

	cap_byte_gen u_cap
	(
		.idx(idx),
		.volt_class(cap_cfg_volt),
		.ma_sel(cap_cfg_ma),
		.clk_code(cap_cfg_clk),
		.ext_chan(cap_cfg_ext),
		.iface_on(cap_cfg_iface),
		.frontend(cap_cfg_front),
		.data_byte(cap_byte),
		.total_len(cap_len)
	);

	// The card advertisement is a pin, so it is synchronised first.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cap_sync1 <= 1'b0;
			cap_sync <= 1'b0;
		end
		else
		begin
			cap_sync1 <= card_cap_supported;
			cap_sync <= cap_sync1;
		end
	end

	// R14: blocks never exceed 255 bytes.
	assign remain = sc_total - sent;
	assign blk_len = (remain > {8'h00, `MAX_BLOCK}) ? `MAX_BLOCK : remain[7:0];
	// Software feeds secure channel payload one byte at a time.
	assign sc_byte_ok = tx_full;
	// Another block follows; busy is still high in S_NEXT, so it cannot tell the loop apart from the end.
	assign more_blk = is_sc && (rsp_phase ? (last_sw == `SW_MORE_RSP) :
		((last_sw == `SW_MORE_CMD && sent < sc_total) || last_sw == `SW_RSP_READY));

	// Write channel: address and data taken in either order, one at a time.
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign ar_idx = s_axi_araddr[5:2];

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_idx <= 4'h0;
			w_hold <= 32'h00000000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_idx <= s_axi_awaddr[5:2];
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_hold <= s_axi_wdata;
			end
			if (wr_fire)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_idx > `REG_TXDATA) ? 2'h2 : 2'h0;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel with status and last card answer.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			case (ar_idx)
				`REG_CAP: s_axi_rdata <= {8'h00, cap_cfg_clk, cap_cfg_volt, 2'h0, cap_cfg_ma,
					1'b0, cap_cfg_front, cap_cfg_iface, cap_cfg_ext};
				`REG_SC: s_axi_rdata <= {sc_total, 11'h000, sc_tlv, 1'b0, sc_sub};
				`REG_STATUS: s_axi_rdata <= {27'h0000000, sel_ok, cap_sent, err, done, busy};
				`REG_SW: s_axi_rdata <= {16'h0000, last_sw};
				`REG_RXDATA: s_axi_rdata <= {24'h000000, rx_byte};
				`REG_TXDATA: s_axi_rdata <= {23'h000000, tx_full, tx_byte};
				`REG_CTRL: s_axi_rdata <= 32'h00000000;
				default:
				begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	always @*
	begin
		next_state = state;
		case (state)
			S_IDLE:
			begin
				// R22: capability only when the card allows it.
				if (wr_fire && aw_idx == `REG_CTRL && w_hold[`CTRL_START_CAP] && cap_sync)
					next_state = S_HDR;
				else if (wr_fire && aw_idx == `REG_CTRL && w_hold[`CTRL_START_SC])
					next_state = S_HDR;
			end
			// The block length loads on this same edge, so decide from its source rather than blk_cnt.
			S_HDR: next_state = (rsp_phase || (is_sc && blk_len == 8'h00)) ? S_WAIT : S_DATA;
			S_DATA:
			begin
				if (cmd_data_valid && cmd_data_ready && idx == blk_cnt - 8'h01)
					next_state = S_WAIT;
			end
			S_WAIT:
			begin
				if (rsp_done)
					next_state = S_NEXT;
			end
			S_NEXT: next_state = more_blk ? S_HDR : S_IDLE;
			default: next_state = S_IDLE;
		endcase
	end

	// Command sequencing and configuration.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= S_IDLE;
			is_sc <= 1'b0;
			cap_cfg_volt <= 8'h00;
			cap_cfg_ma <= 2'h0;
			cap_cfg_clk <= `CLK_NONE;
			cap_cfg_ext <= 1'b0;
			cap_cfg_iface <= 1'b0;
			cap_cfg_front <= 1'b0;
			sc_sub <= 3'h0;
			sc_tlv <= 1'b1;
			sc_total <= 16'h0000;
			sent <= 16'h0000;
			blk_cnt <= 8'h00;
			idx <= 8'h00;
			rsp_phase <= 1'b0;
			first_blk <= 1'b1;
			p2_code <= `P2_FIRST_CMD;
			busy <= 1'b0;
			done <= 1'b0;
			err <= 1'b0;
			cap_sent <= 1'b0;
			sel_ok <= 1'b0;
			last_sw <= 16'h0000;
			rx_byte <= 8'h00;
			tx_byte <= 8'h00;
			tx_full <= 1'b0;
			cmd_start <= 1'b0;
			cmd_ins <= 8'h00;
			cmd_p1 <= 8'h00;
			cmd_p2 <= 8'h00;
			cmd_lc <= 8'h00;
			cmd_le <= 8'h00;
			cmd_data_valid <= 1'b0;
			cmd_data <= 8'h00;
		end
		else
		begin
			state <= next_state;
			cmd_start <= 1'b0;
			if (rsp_valid)
				rx_byte <= rsp_data;
			if (wr_fire && aw_idx == `REG_TXDATA && !tx_full)
			begin
				tx_byte <= w_hold[7:0];
				tx_full <= 1'b1;
			end
			if (wr_fire && aw_idx == `REG_CAP && !busy)
			begin
				cap_cfg_ext <= w_hold[0];
				cap_cfg_iface <= w_hold[1];
				cap_cfg_front <= w_hold[2];
				cap_cfg_ma <= w_hold[5:4];
				cap_cfg_volt <= w_hold[15:8];
				cap_cfg_clk <= w_hold[23:16];
			end
			if (wr_fire && aw_idx == `REG_SC && !busy)
			begin
				sc_sub <= w_hold[2:0];
				sc_tlv <= w_hold[4];
				sc_total <= w_hold[31:16];
			end
			// R4: selection allowed after capability went out, or when the card does not advertise it.
			if (wr_fire && aw_idx == `REG_CTRL && w_hold[`CTRL_SELECT])
				sel_ok <= cap_sent || !cap_sync;
			if (wr_fire && aw_idx == `REG_CTRL && w_hold[`CTRL_SESSION])
			begin
				cap_sent <= 1'b0;
				sel_ok <= 1'b0;
			end
			case (state)
				S_IDLE:
				begin
					if (next_state == S_HDR)
					begin
						busy <= 1'b1;
						done <= 1'b0;
						err <= 1'b0;
						is_sc <= !(w_hold[`CTRL_START_CAP] && cap_sync);
						sent <= 16'h0000;
						rsp_phase <= 1'b0;
						first_blk <= 1'b1;
						p2_code <= `P2_FIRST_CMD;
					end
				end
				S_HDR:
				begin
					// R1: capability header has Lc and no Le.
					cmd_start <= 1'b1;
					cmd_ins <= hdr_ins;
					cmd_p1 <= hdr_p1;
					cmd_p2 <= hdr_p2;
					cmd_lc <= rsp_phase ? 8'h00 : (is_sc ? blk_len : cap_len);
					cmd_le <= rsp_phase ? `MAX_BLOCK : 8'h00;
					blk_cnt <= rsp_phase ? 8'h00 : (is_sc ? blk_len : cap_len);
					idx <= 8'h00;
				end
				S_DATA:
				begin
					// R13: software supplies the wrap tag first.
					if (!cmd_data_valid && (!is_sc || sc_byte_ok))
					begin
						cmd_data_valid <= 1'b1;
						cmd_data <= is_sc ? tx_byte : cap_byte;
						if (is_sc)
							tx_full <= 1'b0;
					end
					else if (cmd_data_valid && cmd_data_ready)
					begin
						cmd_data_valid <= 1'b0;
						idx <= idx + 8'h01;
					end
				end
				S_WAIT:
				begin
					if (rsp_done)
					begin
						last_sw <= rsp_sw;
						if (!rsp_phase)
							sent <= sent + {8'h00, blk_cnt};
					end
				end
				S_NEXT:
				begin
					if (!is_sc)
					begin
						busy <= 1'b0;
						done <= 1'b1;
						cap_sent <= (last_sw == `SW_OK);
						err <= (last_sw != `SW_OK);
					end
					// R16: more command blocks follow.
					else if (!rsp_phase && last_sw == `SW_MORE_CMD && sent < sc_total)
						p2_code <= `P2_NEXT_CMD;
					// R17: command complete, fetch response.
					else if (!rsp_phase && last_sw == `SW_RSP_READY)
					begin
						rsp_phase <= 1'b1;
						p2_code <= `P2_FIRST_RSP;
					end
					// R18: more response blocks remain.
					else if (rsp_phase && last_sw == `SW_MORE_RSP)
						p2_code <= `P2_NEXT_RSP;
					// R19: operation finished.
					else if (last_sw == `SW_OK)
					begin
						busy <= 1'b0;
						done <= 1'b1;
					end
					else
					begin
						busy <= 1'b0;
						done <= 1'b1;
						err <= 1'b1;
					end
				end
				default:
				begin
					busy <= 1'b0;
				end
			endcase
		end
	end
endmodule

// File: term_cmd_ctrl_properties.sv
// Assertions on the controller's command header and data bytes toward the card.
`timescale 1ns/10ps
module term_cmd_ctrl_checker
(
	input wire aclk,
	input wire aresetn,
	input wire cmd_start,
	input wire [7:0] cmd_ins,
	input wire [7:0] cmd_p1,
	input wire [7:0] cmd_p2,
	input wire [7:0] cmd_lc,
	input wire [7:0] cmd_le,
	input wire cmd_data_valid,
	input wire [7:0] cmd_data,
	input wire cmd_data_ready
);
	reg [7:0] byte_idx;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Index of the byte now offered; a new header restarts the count.
	always @(posedge aclk)
	begin
		if (!aresetn || cmd_start)
			byte_idx <= 8'h00;
		else if (cmd_data_valid && cmd_data_ready)
			byte_idx <= byte_idx + 8'h01;
	end
	sequence cap_at(int n);
		cmd_data_valid && cmd_ins == 8'hAA && byte_idx == n;
	endsequence
	sequence sc_hdr;
		cmd_start && cmd_ins == 8'h73;
	endsequence
	a_cap_params: assert property (cmd_start && cmd_ins == 8'hAA |-> !(cmd_p1 | cmd_p2 | cmd_le))
		else $error("capability header wrong");
	a_cap_tag: assert property (cap_at(0) |-> cmd_data == 8'hA9)
		else $error("template tag wrong");
	a_cap_length: assert property (cap_at(1) |-> cmd_data == cmd_lc - 8'h02)
		else $error("template length wrong");
	a_power_tag: assert property (cap_at(2) |-> cmd_data == 8'h80)
		else $error("power object tag wrong");
	a_current_code: assert property (cap_at(5) |-> cmd_data inside {8'h0A, 8'h1E, 8'h3C})
		else $error("current code wrong");
	a_clock_code: assert property (cap_at(6) |-> cmd_data >= 8'h0A)
		else $error("clock code below range");
	a_sc_p1: assert property (sc_hdr |-> cmd_p1 <= 8'h04)
		else $error("sub-procedure byte wrong");
	a_sc_p2: assert property (sc_hdr |-> cmd_p2 inside {8'h80, 8'h00, 8'hA0, 8'h20})
		else $error("block code wrong");
	a_lc_bound: assert property (cmd_data_valid |-> byte_idx < cmd_lc)
		else $error("more bytes than length");
	a_rsp_nodata: assert property (sc_hdr ##0 cmd_p2[5] |-> cmd_lc == 8'h00)
		else $error("response fetch carries data");
endmodule
bind term_cmd_ctrl term_cmd_ctrl_checker u_chk (.aclk(aclk), .aresetn(aresetn), .cmd_start(cmd_start),
	.cmd_ins(cmd_ins), .cmd_p1(cmd_p1), .cmd_p2(cmd_p2), .cmd_lc(cmd_lc), .cmd_le(cmd_le),
	.cmd_data_valid(cmd_data_valid), .cmd_data(cmd_data), .cmd_data_ready(cmd_data_ready));

// File: card_model.sv
// Behavioural card that answers capability and chained secure channel commands.
`timescale 1ns/10ps
module card_model
(
	input wire aclk,
	input wire aresetn,
	input wire slow,
	input wire [15:0] cmd_total,
	input wire [15:0] rsp_total,
	input wire cmd_start,
	input wire [7:0] cmd_ins,
	input wire [7:0] cmd_p1,
	input wire [7:0] cmd_p2,
	input wire [7:0] cmd_lc,
	input wire [7:0] cmd_le,
	input wire cmd_data_valid,
	input wire [7:0] cmd_data,
	output reg cmd_data_ready,
	output reg rsp_valid,
	output reg [7:0] rsp_data,
	output reg rsp_done,
	output reg [15:0] rsp_sw
);
	reg [7:0] rx_mem [0:511];
	reg [15:0] pos, rpos;
	reg [8:0] left;
	reg [7:0] n_cmd, last_p1;
	reg [1:0] phase;
	reg is_cap, rsp_op, tick;
	reg [4:0] chan_limit;
	// Free toggle that halves the accept rate when stalling.
	always @(posedge aclk)
		tick <= aresetn ? ~tick : 1'b0;
	// Idle lines toggle so a stale byte is never mistaken for data.
	always @(posedge aclk)
	begin
		rsp_done <= 1'b0;
		rsp_valid <= 1'b0;
		rsp_data <= ~rsp_data;
		rsp_sw <= ~rsp_sw;
		cmd_data_ready <= 1'b0;
		if (!aresetn)
		begin
			phase <= 2'd0;
			n_cmd <= 8'h00;
			chan_limit <= 5'd3;
			rsp_data <= 8'h00;
			rsp_sw <= 16'h0000;
		end
		else if (cmd_start)
		begin
			n_cmd <= n_cmd + 8'h01;
			last_p1 <= cmd_p1;
			is_cap <= cmd_ins == 8'hAA;
			rsp_op <= cmd_p2[5];
			if (cmd_ins == 8'hAA || cmd_p2[7:5] == 3'b100)
				pos <= 16'h0000;
			if (cmd_p2[7:5] == 3'b101)
				rpos <= 16'h0000;
			left <= cmd_p2[5] ? ((cmd_le == 8'h00) ? 9'h100 : {1'b0, cmd_le}) : {1'b0, cmd_lc};
			phase <= 2'd1;
		end
		else if (phase == 2'd1 && !rsp_op)
		begin
			if (left == 9'd0)
				phase <= 2'd2;
			else if (cmd_data_valid && cmd_data_ready)
			begin
				rx_mem[pos[8:0]] <= cmd_data;
				// only three extra channels unless the extended object follows power.
				if (is_cap && pos == 16'd7)
					chan_limit <= (cmd_data == 8'h81) ? 5'd19 : 5'd3;
				pos <= pos + 16'h0001;
				left <= left - 9'd1;
			end
			else
				cmd_data_ready <= !slow || tick;
		end
		else if (phase == 2'd1)
		begin
			if (left == 9'd0 || rpos == rsp_total)
				phase <= 2'd2;
			else
			begin
				rsp_valid <= 1'b1;
				rsp_data <= rpos[7:0];
				rpos <= rpos + 16'h0001;
				left <= left - 9'd1;
			end
		end
		else if (phase == 2'd2)
		begin
			rsp_done <= 1'b1;
			phase <= 2'd0;
			if (is_cap)
				rsp_sw <= 16'h9000;
			else if (!rsp_op)
				rsp_sw <= (pos < cmd_total) ? 16'h63F1 : 16'h62F3;
			else
				rsp_sw <= (rpos < rsp_total) ? 16'h62F1 : 16'h9000;
		end
	end
endmodule

// File: term_cmd_ctrl_tb_top.sv
// Self-checking bench driving the controller over its register bus against a card model.
`timescale 1ns/10ps
module term_cmd_ctrl_tb_top;
	reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, slow, cap_sup;
	reg [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;
	reg [15:0] cmd_total, rsp_total;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire cmd_start, cmd_data_valid, cmd_data_ready, rsp_valid, rsp_done;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [7:0] cmd_ins, cmd_p1, cmd_p2, cmd_lc, cmd_le, cmd_data, rsp_data;
	wire [15:0] rsp_sw;
	integer num_errors, compares, cycles, i;
	reg [31:0] rd;
	reg [1:0] rr;
	term_cmd_ctrl u_term_cmd_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmd_start,
		.cmd_ins, .cmd_p1, .cmd_p2, .cmd_lc, .cmd_le, .cmd_data_valid, .cmd_data, .cmd_data_ready, .rsp_valid,
		.rsp_data, .rsp_done, .rsp_sw, .card_cap_supported(cap_sup));
	card_model u_card_model (.aclk, .aresetn, .slow, .cmd_total, .rsp_total, .cmd_start, .cmd_ins, .cmd_p1,
		.cmd_p2, .cmd_lc, .cmd_le, .cmd_data_valid, .cmd_data, .cmd_data_ready, .rsp_valid, .rsp_data, .rsp_done,
		.rsp_sw);
	task check(input [31:0] seen, input [31:0] exp);
	begin
		compares = compares + 1;
		if (seen !== exp)
		begin
			num_errors = num_errors + 1;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	end
	endtask
	// Address and data go out together; each drops once taken, then the response is awaited.
	task axi_wr(input [31:0] a, input [31:0] d);
	begin
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
	end
	endtask
	task axi_rd(input [31:0] a);
	begin
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	end
	endtask
	// Polls status until busy falls; the timeout catches a controller that never finishes.
	task wait_idle;
	begin
		do
			axi_rd(32'h0C);
		while (rd[0] !== 1'b0);
		check(rd[2:1], 2'b01);
	end
	endtask
	task test_bus;
	begin
		axi_wr(32'h1C, 32'h0);
		check(rr, 2'b10);
		axi_rd(32'h1C);
		check({rr, rd}, {2'b10, 32'h0});
		$display("test_bus done");
	end
	endtask
	task test_cap;
	begin
		axi_wr(32'h04, 32'h00050317);
		axi_wr(32'h00, 32'h1);
		repeat (20) @(posedge aclk);
		check(u_card_model.n_cmd, 8'h00);
		cap_sup <= 1'b1;
		repeat (4) @(posedge aclk);
		axi_wr(32'h00, 32'h4);
		axi_wr(32'h00, 32'h1);
		wait_idle;
		for (i = 0; i < 12; i = i + 1)
			check(u_card_model.rx_mem[i], 96'hA90A8003031EFF8100820101 >> (88 - 8 * i) & 8'hFF);
		axi_rd(32'h10);
		check(rd[15:0], 16'h9000);
		axi_wr(32'h00, 32'h8);
		axi_rd(32'h0C);
		check(rd[4:3], 2'b11);
		check(u_card_model.chan_limit, 5'd19);
		$display("test_cap done");
	end
	endtask
	task test_sc;
	begin
		slow <= 1'b1;
		axi_wr(32'h08, 32'h012C0013);
		axi_wr(32'h00, 32'h2);
		for (i = 0; i < 300; i = i + 1)
		begin
			do
				axi_rd(32'h18);
			while (rd[8] !== 1'b0);
			axi_wr(32'h18, (i == 0) ? 32'h73 : i & 32'hFF);
		end
		wait_idle;
		check(u_card_model.pos, 16'd300);
		check(u_card_model.rx_mem[0], 8'h73);
		for (i = 0; i < 300; i = i + 1)
			check(u_card_model.rx_mem[i], (i == 0) ? 32'h73 : i & 32'hFF);
		check(u_card_model.n_cmd, 8'h05);
		check(u_card_model.last_p1, 8'h03);
		axi_rd(32'h10);
		check(rd[15:0], 16'h9000);
		axi_rd(32'h14);
		check(rd[7:0], 8'h2B);
		$display("test_sc done");
	end
	endtask
	task finish_test;
	begin
		$display("errors=%0d compares=%0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	// Free-running clock at 125 MHz.
	initial
	begin
		aclk = 1'b0;
		forever
			#4 aclk = ~aclk;
	end
	// Cycle ceiling well above the longest expected run.
	always @(posedge aclk)
	begin
		cycles = cycles + 1;
		if (cycles == 40000)
		begin
			num_errors = num_errors + 1;
			finish_test;
		end
	end
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, slow, cap_sup} = 8'h00;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		cmd_total = 16'd300;
		rsp_total = 16'd300;
		{num_errors, compares, cycles} = 96'h0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		test_bus;
		test_cap;
		test_sc;
		finish_test;
	end
endmodule
